// ### mcuio_map.svh
`ifndef MCUIO_MAP_SVH
`define MCUIO_MAP_SVH

// Data and program counter constants of the execution unit.
`define MCUIO_ACC_RESET   8'h00
`define MCUIO_BYTE_ZERO   8'h00
`define MCUIO_BYTE_ONE    8'h01
`define MCUIO_BYTE_ONES   8'hFF
`define MCUIO_PC_ZERO     11'h000
`define MCUIO_PC_ONE      11'h001
`define MCUIO_TRAP_VECTOR 11'h001
`define MCUIO_ADDR_ZERO   7'h00

// Valid selector range of the auxiliary-page special registers.
`define MCUIO_SFR_MIN     4'h5
`define MCUIO_SFR_MAX     4'hF

`endif

// ### mcuio_pkg.sv
`default_nettype none

package mcuio_pkg;

    // Decoded operation handed over by the fetch and decode stage.
    typedef enum logic [2:0] {
        OP_INCREMENT_REGISTER,
        OP_INCREMENT_SKIP_ZERO,
        OP_SOFTWARE_TRAP,
        OP_OR_ACCUMULATOR_REGISTER,
        OP_OR_IMMEDIATE_ACCUMULATOR,
        OP_READ_FPAGE_REGISTER
    } mcuio_op_t;

    // Sequencer states for the multi-cycle operations.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SKIP,
        ST_TRAP_LOAD,
        ST_TRAP_END
    } mcuio_state_t;

endpackage

`default_nettype wire

// ### mcuio_exec.sv
// What this block does
// - Increment adds one to the addressed data register 0..127 and writes the accumulator or the register.
// - Increment finishes in one cycle, updates the zero flag, and all ones wraps to zero with the flag set.
// - Increment-and-skip stores like increment and on a zero result discards the prefetched instruction.
// - Increment-and-skip takes one cycle on a nonzero result and two cycles when it skips.
// - The software trap first pushes the program counter plus one onto the call stack.
// - The software trap then loads the 11-bit program counter with 0x001 and takes three cycles.
// - OR with a register stores accumulator OR register per the destination, updates zero, in one cycle.
// - OR with an immediate stores accumulator OR the 8-bit immediate in the accumulator, updates zero.
// - The auxiliary-page read copies the special register 5..15 into the accumulator in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mcuio_map.svh"

module mcuio_exec (
    input  wire logic                 i_clock,
    input  wire logic                 i_resetn,
    input  wire logic                 i_valid,
    input  wire mcuio_pkg::mcuio_op_t i_op,
    input  wire logic [6:0]           i_reg_addr,
    input  wire logic                 i_dest,
    input  wire logic [7:0]           i_imm,
    input  wire logic [3:0]           i_sfr_sel,
    input  wire logic [7:0]           i_reg_rdata,
    input  wire logic [7:0]           i_sfr_rdata,
    input  wire logic [10:0]          i_pc,
    output logic                      o_ready,
    output logic [7:0]                o_acc,
    output logic                      o_zero,
    output logic                      o_reg_we,
    output logic [6:0]                o_reg_waddr,
    output logic [7:0]                o_reg_wdata,
    output logic                      o_discard,
    output logic                      o_stack_push,
    output logic [10:0]               o_stack_data,
    output logic                      o_pc_load,
    output logic [10:0]               o_pc_value
);

    mcuio_pkg::mcuio_state_t state_ff;
    mcuio_pkg::mcuio_state_t nxt_state;
    logic [7:0]              acc_ff;
    logic                    zero_ff;
    logic                    reg_we_ff;
    logic [6:0]              reg_waddr_ff;
    logic [7:0]              reg_wdata_ff;
    logic                    discard_ff;
    logic                    push_ff;
    logic [10:0]             push_data_ff;
    logic                    pc_load_ff;
    logic [10:0]             pc_value_ff;
    logic                    accept;
    logic [7:0]              inc_val;
    logic [7:0]              or_reg_val;
    logic [7:0]              or_imm_val;
    logic                    sfr_ok;
    logic [10:0]             ret_addr;

    // A new instruction is taken only while no multi-cycle operation runs.
    assign o_ready    = (state_ff == mcuio_pkg::ST_IDLE);
    assign accept     = i_valid && o_ready;
    assign inc_val    = i_reg_rdata + `MCUIO_BYTE_ONE;
    assign or_reg_val = acc_ff | i_reg_rdata;
    assign or_imm_val = acc_ff | i_imm;
    // The 4-bit selector cannot pass the top of the range, so only the lower bound needs a test.
    assign sfr_ok     = (i_sfr_sel >= `MCUIO_SFR_MIN);
    assign ret_addr   = i_pc + `MCUIO_PC_ONE;

    // Outputs are the registered results.
    assign o_acc        = acc_ff;
    assign o_zero       = zero_ff;
    assign o_reg_we     = reg_we_ff;
    assign o_reg_waddr  = reg_waddr_ff;
    assign o_reg_wdata  = reg_wdata_ff;
    assign o_discard    = discard_ff;
    assign o_stack_push = push_ff;
    assign o_stack_data = push_data_ff;
    assign o_pc_load    = pc_load_ff;
    assign o_pc_value   = pc_value_ff;

    // Sequencer for the skip and trap operations.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mcuio_pkg::ST_IDLE: begin
                if (accept && i_op == mcuio_pkg::OP_INCREMENT_SKIP_ZERO && inc_val == `MCUIO_BYTE_ZERO) begin
                    nxt_state = mcuio_pkg::ST_SKIP;
                end else if (accept && i_op == mcuio_pkg::OP_SOFTWARE_TRAP) begin
                    nxt_state = mcuio_pkg::ST_TRAP_LOAD;
                end
            end
            mcuio_pkg::ST_SKIP:      nxt_state = mcuio_pkg::ST_IDLE;
            mcuio_pkg::ST_TRAP_LOAD: nxt_state = mcuio_pkg::ST_TRAP_END;
            mcuio_pkg::ST_TRAP_END:  nxt_state = mcuio_pkg::ST_IDLE;
            default:                 nxt_state = mcuio_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= mcuio_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Accumulator and zero flag; other flags live elsewhere and are never touched.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_ff  <= `MCUIO_ACC_RESET;
            zero_ff <= 1'b0;
        end else if (accept) begin
            case (i_op)
                mcuio_pkg::OP_INCREMENT_REGISTER: begin
                    if (!i_dest) begin
                        acc_ff <= inc_val;
                    end
                    zero_ff <= (inc_val == `MCUIO_BYTE_ZERO);
                end
                mcuio_pkg::OP_INCREMENT_SKIP_ZERO: begin
                    if (!i_dest) begin
                        acc_ff <= inc_val;
                    end
                end
                mcuio_pkg::OP_OR_ACCUMULATOR_REGISTER: begin
                    if (!i_dest) begin
                        acc_ff <= or_reg_val;
                    end
                    zero_ff <= (or_reg_val == `MCUIO_BYTE_ZERO);
                end
                mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR: begin
                    acc_ff  <= or_imm_val;
                    zero_ff <= (or_imm_val == `MCUIO_BYTE_ZERO);
                end
                mcuio_pkg::OP_READ_FPAGE_REGISTER: begin
                    if (sfr_ok) begin
                        acc_ff <= i_sfr_rdata;
                    end
                end
                default: begin
                    acc_ff <= acc_ff;
                end
            endcase
        end
    end

    // Data register write-back, one cycle after the instruction is taken.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            reg_we_ff    <= 1'b0;
            reg_waddr_ff <= `MCUIO_ADDR_ZERO;
            reg_wdata_ff <= `MCUIO_BYTE_ZERO;
        end else begin
            reg_we_ff <= 1'b0;
            if (accept && i_dest) begin
                case (i_op)
                    mcuio_pkg::OP_INCREMENT_REGISTER, mcuio_pkg::OP_INCREMENT_SKIP_ZERO: begin
                        reg_we_ff    <= 1'b1;
                        reg_waddr_ff <= i_reg_addr;
                        reg_wdata_ff <= inc_val;
                    end
                    mcuio_pkg::OP_OR_ACCUMULATOR_REGISTER: begin
                        reg_we_ff    <= 1'b1;
                        reg_waddr_ff <= i_reg_addr;
                        reg_wdata_ff <= or_reg_val;
                    end
                    default: begin
                        reg_we_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Prefetch discard pulse during the skip cycle.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            discard_ff <= 1'b0;
        end else begin
            discard_ff <= (nxt_state == mcuio_pkg::ST_SKIP);
        end
    end

    // Trap: push the return address, then load the vector a cycle later.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            push_ff      <= 1'b0;
            push_data_ff <= `MCUIO_PC_ZERO;
            pc_load_ff   <= 1'b0;
            pc_value_ff  <= `MCUIO_PC_ZERO;
        end else begin
            push_ff    <= 1'b0;
            pc_load_ff <= 1'b0;
            if (accept && i_op == mcuio_pkg::OP_SOFTWARE_TRAP) begin
                push_ff      <= 1'b1;
                push_data_ff <= ret_addr;
            end
            if (state_ff == mcuio_pkg::ST_TRAP_LOAD) begin
                pc_load_ff  <= 1'b1;
                pc_value_ff <= `MCUIO_TRAP_VECTOR;
            end
        end
    end

    // Checks on the executed behaviour.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    property p_increment_register_acc;
        accept && i_op == mcuio_pkg::OP_INCREMENT_REGISTER && !i_dest |=> o_acc == $past(inc_val) && !o_reg_we;
    endproperty
    a_increment_register_acc: assert property (p_increment_register_acc) else $error("Increment to accumulator wrong.");

    property p_increment_register_reg;
        accept && i_op == mcuio_pkg::OP_INCREMENT_REGISTER && i_dest |=>
            o_reg_we && o_reg_wdata == $past(inc_val) && o_reg_waddr == $past(i_reg_addr) && $stable(o_acc);
    endproperty
    a_increment_register_reg: assert property (p_increment_register_reg) else $error("Increment to register wrong.");

    property p_increment_register_wrap;
        accept && i_op == mcuio_pkg::OP_INCREMENT_REGISTER && i_reg_rdata == `MCUIO_BYTE_ONES |=> o_zero && o_ready;
    endproperty
    a_increment_register_wrap: assert property (p_increment_register_wrap) else $error("Increment wrap did not set zero.");

    property p_skip;
        accept && i_op == mcuio_pkg::OP_INCREMENT_SKIP_ZERO && inc_val == `MCUIO_BYTE_ZERO |=>
            o_discard && !o_ready ##1 o_ready && !o_discard;
    endproperty
    a_skip: assert property (p_skip) else $error("Skip sequence wrong.");

    property p_no_skip;
        accept && i_op == mcuio_pkg::OP_INCREMENT_SKIP_ZERO && inc_val != `MCUIO_BYTE_ZERO |=> o_ready && !o_discard;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("Nonzero increment-skip took extra cycle.");

    property p_trap_push;
        accept && i_op == mcuio_pkg::OP_SOFTWARE_TRAP |=> o_stack_push && o_stack_data == $past(ret_addr) && !o_pc_load;
    endproperty
    a_trap_push: assert property (p_trap_push) else $error("Trap push wrong.");

    property p_trap_vector;
        accept && i_op == mcuio_pkg::OP_SOFTWARE_TRAP |=> !o_ready ##1 o_pc_load && o_pc_value == `MCUIO_TRAP_VECTOR
            && !o_ready ##1 o_ready && !o_pc_load;
    endproperty
    a_trap_vector: assert property (p_trap_vector) else $error("Trap vector or length wrong.");

    property p_or_reg;
        accept && i_op == mcuio_pkg::OP_OR_ACCUMULATOR_REGISTER && !i_dest |=>
            o_acc == $past(or_reg_val) && o_zero == (o_acc == `MCUIO_BYTE_ZERO) && o_ready;
    endproperty
    a_or_reg: assert property (p_or_reg) else $error("OR with register wrong.");

    property p_or_imm;
        accept && i_op == mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR |=> o_acc == $past(or_imm_val) && !o_reg_we;
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("OR with immediate wrong.");

    property p_sfr_read;
        accept && i_op == mcuio_pkg::OP_READ_FPAGE_REGISTER && sfr_ok |=>
            o_acc == $past(i_sfr_rdata) && !o_reg_we && $stable(o_zero) && o_ready;
    endproperty
    a_sfr_read: assert property (p_sfr_read) else $error("Special register read wrong.");

    property p_zero_kept;
        accept && (i_op == mcuio_pkg::OP_SOFTWARE_TRAP || i_op == mcuio_pkg::OP_INCREMENT_SKIP_ZERO) |=>
            $stable(o_zero);
    endproperty
    a_zero_kept: assert property (p_zero_kept) else $error("Zero flag changed unexpectedly.");

    property p_zero_imm;
        accept && i_op == mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR |=> o_zero == ($past(or_imm_val) == `MCUIO_BYTE_ZERO);
    endproperty
    a_zero_imm: assert property (p_zero_imm) else $error("Zero flag after OR wrong.");

    c_skip: cover property (accept && i_op == mcuio_pkg::OP_INCREMENT_SKIP_ZERO ##1 o_discard);
    c_trap: cover property (accept && i_op == mcuio_pkg::OP_SOFTWARE_TRAP ##2 o_pc_load);
    c_wrap: cover property (accept && i_op == mcuio_pkg::OP_INCREMENT_REGISTER && i_dest && inc_val == `MCUIO_BYTE_ZERO);
    c_or_zero: cover property (accept && i_op == mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR ##1 o_zero);

endmodule

`default_nettype wire

// ### mcu_increment_register_or_int_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module mcu_increment_register_or_int_ops_tb;
    logic                 i_clock;
    logic                 i_resetn;
    logic                 i_valid;
    mcuio_pkg::mcuio_op_t i_op;
    logic [6:0]           i_reg_addr;
    logic                 i_dest;
    logic [7:0]           i_imm;
    logic [3:0]           i_sfr_sel;
    logic [7:0]           i_reg_rdata;
    logic [7:0]           i_sfr_rdata;
    logic [10:0]          i_pc;
    logic                 o_ready;
    logic [7:0]           o_acc;
    logic                 o_zero;
    logic                 o_reg_we;
    logic [6:0]           o_reg_waddr;
    logic [7:0]           o_reg_wdata;
    logic                 o_discard;
    logic                 o_stack_push;
    logic [10:0]          o_stack_data;
    logic                 o_pc_load;
    logic [10:0]          o_pc_value;
    int                   fails;
    int                   n_checks;
    int                   seed;
    logic [7:0]           acc_m;
    logic                 z_m;
    logic [31:0]          r;

    mcuio_exec DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_valid(i_valid), .i_op(i_op),
        .i_reg_addr(i_reg_addr), .i_dest(i_dest), .i_imm(i_imm), .i_sfr_sel(i_sfr_sel),
        .i_reg_rdata(i_reg_rdata), .i_sfr_rdata(i_sfr_rdata), .i_pc(i_pc), .o_ready(o_ready),
        .o_acc(o_acc), .o_zero(o_zero), .o_reg_we(o_reg_we), .o_reg_waddr(o_reg_waddr),
        .o_reg_wdata(o_reg_wdata), .o_discard(o_discard), .o_stack_push(o_stack_push),
        .o_stack_data(o_stack_data), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value));

    // Free-running core clock.
    always #4 i_clock = ~i_clock;

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Moves to just after the next rising edge, where outputs have settled.
    task automatic step();
        @(posedge i_clock);
        #1;
    endtask

    // Offers an instruction while the unit stalls, which it must ignore.
    task automatic junk();
        i_valid = 1'b1;
        i_op = mcuio_pkg::mcuio_op_t'(3'({$random(seed)} % 6));
        i_reg_rdata = 8'($random(seed));
        i_sfr_rdata = 8'($random(seed));
        i_imm = 8'h00;
    endtask

    // Issues one instruction, updates the model and compares every result.
    task automatic run(input mcuio_pkg::mcuio_op_t op, input logic [6:0] a, input logic d, input logic [7:0] imm,
                       input logic [3:0] sel, input logic [7:0] rd, input logic [7:0] sf, input logic [10:0] pc);
        logic [7:0] res;
        logic       inc;
        logic       orr;
        logic       we;
        logic       sk;
        logic       tr;
        `CHK(o_ready, 1'b1)
        i_valid = 1'b1;
        i_op = op;
        i_reg_addr = a;
        i_dest = d;
        i_imm = imm;
        i_sfr_sel = sel;
        i_reg_rdata = rd;
        i_sfr_rdata = sf;
        i_pc = pc;
        inc = (op == mcuio_pkg::OP_INCREMENT_REGISTER) || (op == mcuio_pkg::OP_INCREMENT_SKIP_ZERO);
        orr = (op == mcuio_pkg::OP_OR_ACCUMULATOR_REGISTER);
        tr = (op == mcuio_pkg::OP_SOFTWARE_TRAP);
        res = inc ? rd + 8'h01 : (orr ? acc_m | rd : acc_m | imm);
        sk = (op == mcuio_pkg::OP_INCREMENT_SKIP_ZERO) && (res == 8'h00);
        we = d && (inc || orr);
        if ((inc || orr) && !d) begin
            acc_m = res;
        end
        if (op == mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR) begin
            acc_m = res;
        end
        if (op == mcuio_pkg::OP_READ_FPAGE_REGISTER && sel >= 4'h5) begin
            acc_m = sf;
        end
        if (orr || op == mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR || op == mcuio_pkg::OP_INCREMENT_REGISTER) begin
            z_m = (res == 8'h00);
        end
        step();
        `CHK(o_acc, acc_m)
        `CHK(o_zero, z_m)
        `CHK(o_reg_we, we)
        if (we) begin
            `CHK(o_reg_waddr, a)
            `CHK(o_reg_wdata, res)
        end
        `CHK(o_discard, sk)
        `CHK(o_stack_push, tr)
        `CHK(o_pc_load, 1'b0)
        if (tr) begin
            `CHK(o_stack_data, pc + 11'h001)
        end
        if (sk || tr) begin
            `CHK(o_ready, 1'b0)
            junk();
            step();
            `CHK(o_discard, 1'b0)
            `CHK(o_reg_we, 1'b0)
        end
        if (tr) begin
            `CHK(o_pc_load, 1'b1)
            `CHK(o_pc_value, 11'h001)
            `CHK(o_ready, 1'b0)
            `CHK(o_stack_push, 1'b0)
            step();
            `CHK(o_pc_load, 1'b0)
        end
        `CHK(o_acc, acc_m)
        `CHK(o_zero, z_m)
    endtask

    // Hard limit on the run length.
    initial begin
        #100000;
        fails++;
        give_verdict();
    end

    // Directed cases first, then random traffic and a reset in mid-run.
    initial begin
        seed = 32'hAECE;
        {i_clock, i_resetn, i_valid, i_dest, i_imm, i_sfr_sel, i_reg_addr, i_reg_rdata, i_sfr_rdata, i_pc} = '0;
        i_op = mcuio_pkg::OP_INCREMENT_REGISTER;
        acc_m = 8'h00;
        z_m = 1'b0;
        repeat (5) @(posedge i_clock);
        #1;
        i_resetn = 1'b1;
        `CHK(o_acc, 8'h00)
        run(mcuio_pkg::OP_INCREMENT_REGISTER, 7'h7F, 1'b1, 8'h00, 4'h0, 8'hFF, 8'h00, 11'h000);
        run(mcuio_pkg::OP_INCREMENT_REGISTER, 7'h00, 1'b0, 8'h00, 4'h0, 8'h41, 8'h00, 11'h000);
        run(mcuio_pkg::OP_INCREMENT_SKIP_ZERO, 7'h10, 1'b1, 8'h00, 4'h0, 8'hFF, 8'h00, 11'h000);
        run(mcuio_pkg::OP_INCREMENT_SKIP_ZERO, 7'h11, 1'b0, 8'h00, 4'h0, 8'hFF, 8'h00, 11'h000);
        run(mcuio_pkg::OP_INCREMENT_SKIP_ZERO, 7'h12, 1'b0, 8'h00, 4'h0, 8'h05, 8'h00, 11'h000);
        run(mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR, 7'h00, 1'b0, 8'hAA, 4'h0, 8'h00, 8'h00, 11'h000);
        run(mcuio_pkg::OP_OR_ACCUMULATOR_REGISTER, 7'h33, 1'b1, 8'h00, 4'h0, 8'h50, 8'h00, 11'h000);
        run(mcuio_pkg::OP_SOFTWARE_TRAP, 7'h00, 1'b0, 8'h00, 4'h0, 8'h00, 8'h00, 11'h0A0);
        for (int s = 0; s < 16; s++) begin
            run(mcuio_pkg::OP_READ_FPAGE_REGISTER, 7'h00, 1'b0, 8'h00, 4'(s), 8'h00,
                8'($random(seed)), 11'h000);
        end
        for (int k = 0; k < 300; k++) begin
            r = $random(seed);
            run(mcuio_pkg::mcuio_op_t'(3'({$random(seed)} % 6)), r[6:0], r[7], 8'($random(seed)), r[11:8],
                (r[13:12] == 2'h0) ? 8'hFF : ((r[13:12] == 2'h1) ? 8'h00 : r[23:16]), 8'($random(seed)),
                {1'b0, r[31:22]});
        end
        i_valid = 1'b0;
        step();
        i_resetn = 1'b0;
        step();
        `CHK(o_acc, 8'h00)
        `CHK(o_ready, 1'b1)
        i_resetn = 1'b1;
        acc_m = 8'h00;
        z_m = 1'b0;
        step();
        run(mcuio_pkg::OP_OR_IMMEDIATE_ACCUMULATOR, 7'h00, 1'b0, 8'h00, 4'h0, 8'h00, 8'h00, 11'h000);
        i_valid = 1'b0;
        step();
        give_verdict();
    end
endmodule

`default_nettype wire
